//--- hdl/rfs_rx_stats.sv
// module: top of the receive frame statistics counters with apb access
`timescale 1ns/1ps
module rfs_rx_stats
	import rfs_pkg::*;
#(
	parameter int BYTE_WIDTH = RFS_BYTE_CNT_WIDTH,
	parameter int FRAME_WIDTH = RFS_FRAME_CNT_WIDTH
) (
	input  wire logic                     pclk,         // 200 MHz clock
	input  wire logic                     presetn,      // async reset, active low
	input  wire logic                     clk_en,       // freezes state while low
	input  wire logic                     psel,         // apb select
	input  wire logic                     penable,      // apb access phase
	input  wire logic                     pwrite,       // apb direction
	input  wire logic [11:0]              paddr,        // apb byte address
	input  wire logic [31:0]              pwdata,       // apb write data
	input  wire logic [3:0]               pstrb,        // apb byte strobes
	output logic      [31:0]              prdata,       // apb read data
	output logic                          pready,       // apb ready
	output logic                          pslverr,      // apb error
	input  wire logic                     frame_done,   // frame status valid, one cycle
	input  wire logic                     frame_error,  // frame had an error
	input  wire logic                     filter_fail,  // failed address filtering
	input  wire logic                     fifo_drop,    // discarded on fifo overflow
	input  wire logic                     is_pause,     // pause frame
	input  wire rfs_class_type            frame_class,  // destination class
	input  wire logic [RFS_LEN_WIDTH-1:0] frame_len,    // frame length in bytes
	input  wire logic                     has_vlan      // frame carries a vlan tag
);
	// *****************************************************************
	// control register
	// *****************************************************************
	logic [RFS_CTL_WIDTH-1:0] receive_filter_control;
	logic [RFS_NUM_FRAME_CNT-1:0] inc;
	logic mcast_byte_en;
	logic [RFS_LEN_WIDTH-1:0] mcast_byte_len;
	logic [BYTE_WIDTH-1:0] mcast_bytes;
	logic [FRAME_WIDTH-1:0] frame_cnt [RFS_NUM_FRAME_CNT];

	// apb decode: single-cycle access, always ready
	wire logic access = psel && penable;
	wire logic wr_ctl = access && pwrite && (paddr == RFS_ADDR_CONTROL) && pstrb[0];

	// software sets strip, accept and forward bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_filter_control <= RFS_CTL_RESET;
		end else if (clk_en && wr_ctl) begin
			receive_filter_control <= pwdata[RFS_CTL_WIDTH-1:0];
		end
	end

	// *****************************************************************
	// frame qualification and counters
	// *****************************************************************
	rfs_frame_qualifier u_qual (
		.frame_done     (frame_done),
		.frame_error    (frame_error),
		.filter_fail    (filter_fail),
		.fifo_drop      (fifo_drop),
		.is_pause       (is_pause),
		.frame_class    (frame_class),
		.frame_len      (frame_len),
		.has_vlan       (has_vlan),
		.ctl            (receive_filter_control),
		.inc            (inc),
		.mcast_byte_en  (mcast_byte_en),
		.mcast_byte_len (mcast_byte_len)
	);

	// byte counter, length zero-extended to counter width
	rfs_counter #(.WIDTH(BYTE_WIDTH)) u_mcast_bytes (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.add_en  (mcast_byte_en),
		.add_val (BYTE_WIDTH'(mcast_byte_len)),
		.count   (mcast_bytes)
	);

	// eight frame counters, each adds one on its enable
	generate
		for (genvar i = 0; i < RFS_NUM_FRAME_CNT; i++) begin : g_frame_cnt
			rfs_counter #(.WIDTH(FRAME_WIDTH)) u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.clk_en  (clk_en),
				.add_en  (inc[i]),
				.add_val (FRAME_WIDTH'(1)),
				.count   (frame_cnt[i])
			);
		end
	endgenerate

	// *****************************************************************
	// read mux
	// *****************************************************************
	function automatic logic [31:0] widen(input logic [FRAME_WIDTH-1:0] v);
		widen = 32'(v);
	endfunction

	logic [31:0] rd_word;
	logic        rd_hit;
	// counters read live; a frame landing mid-read shows next access
	always_comb begin
		rd_hit = 1'b1;
		unique case (paddr)
			RFS_ADDR_MCAST_BYTES:   rd_word = 32'(mcast_bytes);
			RFS_ADDR_UCAST_FRAMES:  rd_word = widen(frame_cnt[RFS_IDX_UCAST]);
			RFS_ADDR_BCAST_FRAMES:  rd_word = widen(frame_cnt[RFS_IDX_BCAST]);
			RFS_ADDR_MCAST_FRAMES:  rd_word = widen(frame_cnt[RFS_IDX_MCAST]);
			RFS_ADDR_PAUSE_FRAMES:  rd_word = widen(frame_cnt[RFS_IDX_PAUSE]);
			RFS_ADDR_LEN64_FRAMES:  rd_word = widen(frame_cnt[RFS_IDX_LEN64]);
			RFS_ADDR_LEN127_FRAMES: rd_word = widen(frame_cnt[RFS_IDX_LEN127]);
			RFS_ADDR_LEN255_FRAMES: rd_word = widen(frame_cnt[RFS_IDX_LEN255]);
			RFS_ADDR_LEN511_FRAMES: rd_word = widen(frame_cnt[RFS_IDX_LEN511]);
			RFS_ADDR_CONTROL:       rd_word = 32'(receive_filter_control);
			default: begin
				rd_word = RFS_ZERO_WORD;
				rd_hit = 1'b0;
			end
		endcase
	end

	// counters are read-only, so a write to one is an error like an unmapped address
	wire logic err = !rd_hit || (pwrite && (paddr != RFS_ADDR_CONTROL));

	assign pready = 1'b1;
	assign pslverr = access && err;

	// read data registered from the setup phase into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= RFS_ZERO_WORD;
		end else if (clk_en && psel && !penable && !pwrite) begin
			prdata <= rd_word;
		end
	end
endmodule // rfs_rx_stats

//--- hdl/rfs_pkg.sv
// package: constants for the receive frame statistics counters
package rfs_pkg;
	// *****************************************************************
	// register map (byte offsets on the apb bus)
	// *****************************************************************
	localparam logic [11:0] RFS_ADDR_MCAST_BYTES = 12'h000;
	localparam logic [11:0] RFS_ADDR_UCAST_FRAMES = 12'h004;
	localparam logic [11:0] RFS_ADDR_BCAST_FRAMES = 12'h008;
	localparam logic [11:0] RFS_ADDR_MCAST_FRAMES = 12'h00C;
	localparam logic [11:0] RFS_ADDR_PAUSE_FRAMES = 12'h010;
	localparam logic [11:0] RFS_ADDR_LEN64_FRAMES = 12'h014;
	localparam logic [11:0] RFS_ADDR_LEN127_FRAMES = 12'h018;
	localparam logic [11:0] RFS_ADDR_LEN255_FRAMES = 12'h01C;
	localparam logic [11:0] RFS_ADDR_LEN511_FRAMES = 12'h020;
	localparam logic [11:0] RFS_ADDR_CONTROL = 12'h024;

	// *****************************************************************
	// control register fields and reset value
	// *****************************************************************
	localparam int RFS_CTL_VLAN_STRIP_BIT = 0;
	localparam int RFS_CTL_FCS_STRIP_BIT = 1;
	localparam int RFS_CTL_BCAST_ACCEPT_BIT = 2;
	localparam int RFS_CTL_PAUSE_FWD_BIT = 3;
	localparam int RFS_CTL_WIDTH = 4;
	localparam logic [3:0] RFS_CTL_RESET = 4'h4;

	// *****************************************************************
	// counter widths and frame length figures
	// *****************************************************************
	localparam int RFS_BYTE_CNT_WIDTH = 32;
	localparam int RFS_FRAME_CNT_WIDTH = 20;
	localparam int RFS_LEN_WIDTH = 14;
	localparam logic [13:0] RFS_LEN_64 = 14'h0040;
	localparam logic [13:0] RFS_LEN_65 = 14'h0041;
	localparam logic [13:0] RFS_LEN_127 = 14'h007F;
	localparam logic [13:0] RFS_LEN_128 = 14'h0080;
	localparam logic [13:0] RFS_LEN_255 = 14'h00FF;
	localparam logic [13:0] RFS_LEN_256 = 14'h0100;
	localparam logic [13:0] RFS_LEN_511 = 14'h01FF;
	localparam logic [13:0] RFS_VLAN_TAG_BYTES = 14'h0004;
	localparam logic [13:0] RFS_FCS_BYTES = 14'h0004;

	// *****************************************************************
	// frame classes and counter indices
	// *****************************************************************
	typedef enum logic [1:0] {
		RFS_CLASS_UCAST = 2'h0,
		RFS_CLASS_MCAST = 2'h1,
		RFS_CLASS_BCAST = 2'h2
	} rfs_class_type;

	localparam int RFS_NUM_FRAME_CNT = 8;
	localparam int RFS_IDX_UCAST = 0;
	localparam int RFS_IDX_BCAST = 1;
	localparam int RFS_IDX_MCAST = 2;
	localparam int RFS_IDX_PAUSE = 3;
	localparam int RFS_IDX_LEN64 = 4;
	localparam int RFS_IDX_LEN127 = 5;
	localparam int RFS_IDX_LEN255 = 6;
	localparam int RFS_IDX_LEN511 = 7;
	localparam logic [31:0] RFS_ZERO_WORD = 32'h0000_0000;
endpackage

//--- hdl/rfs_counter.sv
// module: one wrapping statistics counter with add input
`timescale 1ns/1ps
module rfs_counter
	import rfs_pkg::*;
#(
	parameter int WIDTH = 20
) (
	input  wire logic             pclk,     // bus clock
	input  wire logic             presetn,  // async reset, active low
	input  wire logic             clk_en,   // freezes state while low
	input  wire logic             add_en,   // add this cycle
	input  wire logic [WIDTH-1:0] add_val,  // amount to add
	output logic      [WIDTH-1:0] count     // current count
);
	// *****************************************************************
	// counter
	// *****************************************************************
	// sum truncated to width so the count wraps on overflow
	wire logic [WIDTH-1:0] next_count = count + add_val;

	// cleared by reset, advanced only on qualified frames
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (clk_en && add_en) begin
			count <= next_count;
		end
	end
endmodule // rfs_counter

//--- hdl/rfs_frame_qualifier.sv
// module: per-frame decision which counters a completed frame advances
`timescale 1ns/1ps
module rfs_frame_qualifier
	import rfs_pkg::*;
(
	input  wire logic                     frame_done,      // frame status strobe
	input  wire logic                     frame_error,     // frame had an error
	input  wire logic                     filter_fail,     // failed address filtering
	input  wire logic                     fifo_drop,       // discarded on fifo overflow
	input  wire logic                     is_pause,        // pause frame
	input  wire rfs_class_type            frame_class,     // destination class
	input  wire logic [RFS_LEN_WIDTH-1:0] frame_len,       // length on the wire
	input  wire logic                     has_vlan,        // frame carries a vlan tag
	input  wire logic [RFS_CTL_WIDTH-1:0] ctl,             // control bits
	output logic [RFS_NUM_FRAME_CNT-1:0]  inc,             // per-counter increment
	output logic                          mcast_byte_en,   // add to byte counter
	output logic [RFS_LEN_WIDTH-1:0]      mcast_byte_len   // bytes to add
);
	// *****************************************************************
	// qualification terms
	// *****************************************************************
	wire logic good = frame_done && !frame_error && !fifo_drop;
	// pause frames dropped for lack of forwarding count as filtered out
	wire logic pause_blocked = is_pause && !ctl[RFS_CTL_PAUSE_FWD_BIT];
	wire logic passed = good && !filter_fail && !pause_blocked;
	wire logic in_range_64 = (frame_len == RFS_LEN_64);
	wire logic in_range_127 = (frame_len >= RFS_LEN_65) && (frame_len <= RFS_LEN_127);
	wire logic in_range_255 = (frame_len >= RFS_LEN_128) && (frame_len <= RFS_LEN_255);
	wire logic in_range_511 = (frame_len >= RFS_LEN_256) && (frame_len <= RFS_LEN_511);
	wire logic [RFS_LEN_WIDTH-1:0] vlan_cut = (ctl[RFS_CTL_VLAN_STRIP_BIT] && has_vlan) ?
		RFS_VLAN_TAG_BYTES : '0;
	wire logic [RFS_LEN_WIDTH-1:0] fcs_cut = ctl[RFS_CTL_FCS_STRIP_BIT] ? RFS_FCS_BYTES : '0;

	// *****************************************************************
	// counter enables
	// *****************************************************************
	// length bins past 64 follow only address filtering, not pause forwarding
	wire logic bin_ok = good && !filter_fail;
	assign inc[RFS_IDX_UCAST] = passed && (frame_class == RFS_CLASS_UCAST);
	assign inc[RFS_IDX_BCAST] = good && (frame_class == RFS_CLASS_BCAST) &&
		ctl[RFS_CTL_BCAST_ACCEPT_BIT];
	assign inc[RFS_IDX_MCAST] = passed && (frame_class == RFS_CLASS_MCAST);
	assign inc[RFS_IDX_PAUSE] = good && is_pause;
	assign inc[RFS_IDX_LEN64] = passed && in_range_64;
	assign inc[RFS_IDX_LEN127] = bin_ok && in_range_127;
	assign inc[RFS_IDX_LEN255] = bin_ok && in_range_255;
	assign inc[RFS_IDX_LEN511] = bin_ok && in_range_511;
	assign mcast_byte_en = passed && (frame_class == RFS_CLASS_MCAST);
	assign mcast_byte_len = frame_len - vlan_cut - fcs_cut;
endmodule // rfs_frame_qualifier

//--- verif/rfs_rx_stats_props.sv
// checker: bus and reset relations at the statistics block ports
`timescale 1ns/1ps
module rfs_rx_stats_chk
	import rfs_pkg::*;
#(
	parameter int BYTE_WIDTH  = 32,
	parameter int FRAME_WIDTH = 20
) (
	input wire logic        pclk,       // clock
	input wire logic        presetn,    // reset, active low
	input wire logic        psel,       // select
	input wire logic        penable,    // access phase
	input wire logic        pwrite,     // direction
	input wire logic [11:0] paddr,      // byte address
	input wire logic [31:0] prdata,     // read data
	input wire logic        pready,     // ready
	input wire logic        pslverr,    // error
	input wire logic        frame_done  // frame strobe
);
	// access cycle, and a read of one frame counter
	wire acc = psel && penable;
	wire frd = acc && !pwrite && paddr >= RFS_ADDR_UCAST_FRAMES && paddr <= RFS_ADDR_LEN511_FRAMES;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// *****************************************************************
	// assertions
	// *****************************************************************
	a_ready_access: assert property (acc |-> pready) else $error("pready low in access");
	a_err_unmapped: assert property (acc && paddr > RFS_ADDR_CONTROL |-> pslverr) else $error("no error on unmapped");
	a_err_cnt_write: assert property (acc && pwrite && paddr < RFS_ADDR_CONTROL |-> pslverr)
		else $error("no error on counter write");
	a_ctl_no_err: assert property (acc && paddr == RFS_ADDR_CONTROL |-> !pslverr) else $error("error on control");
	a_err_idle: assert property (!psel |-> !pslverr) else $error("error while idle");
	a_frame_width: assert property (frd |-> prdata[31:FRAME_WIDTH] == '0)
		else $error("frame counter above its width");
	a_unmapped_zero: assert property (acc && !pwrite && paddr > RFS_ADDR_CONTROL |-> prdata == RFS_ZERO_WORD)
		else $error("unmapped read not zero");
	// read data only moves at a read setup edge, so idle cycles keep it
	a_read_hold: assert property (!psel |=> $stable(prdata)) else $error("read data moved while idle");
	a_reset_clear: assert property ($rose(presetn) |-> prdata == RFS_ZERO_WORD)
		else $error("read data not clear after reset");
	c_burst: cover property (frame_done [*3]);
	c_ctl_write: cover property (acc && pwrite && paddr == RFS_ADDR_CONTROL);
	c_cnt_read: cover property (frd);
endmodule // rfs_rx_stats_chk

//--- verif/rfs_frame_src.sv
// partner: receive mac and filter status source
`timescale 1ns/1ps
module rfs_frame_src
	import rfs_pkg::*;
(
	input  wire logic                 pclk,        // clock
	output logic                      frame_done,  // status strobe
	output logic                      frame_error, // error flag
	output logic                      filter_fail, // filter result
	output logic                      fifo_drop,   // overflow discard
	output logic                      is_pause,    // pause frame
	output rfs_class_type             frame_class, // destination class
	output logic [RFS_LEN_WIDTH-1:0]  frame_len,   // length in bytes
	output logic                      has_vlan     // tag present
);
	initial begin
		frame_done = 1'b0;
		{frame_error, filter_fail, fifo_drop, is_pause, has_vlan} = 5'h1F;
		frame_class = RFS_CLASS_BCAST;
		frame_len = 14'h3FFF;
	end
	// status for n frames in a row; called just after a clock edge
	task automatic send(input int n, input logic e, f, d, p, input rfs_class_type c,
		input logic [13:0] l, input logic v);
		frame_done <= 1'b1;
		{frame_error, filter_fail, fifo_drop, is_pause, has_vlan} <= {e, f, d, p, v};
		frame_class <= c;
		frame_len <= l;
		repeat (n) @(posedge pclk);
		frame_done <= 1'b0;
		// unqualified lines show the inverse, never a stale copy
		{frame_error, filter_fail, fifo_drop, is_pause, has_vlan} <= ~{e, f, d, p, v};
		frame_class <= rfs_class_type'(~c);
		frame_len <= ~l;
	endtask
endmodule // rfs_frame_src

//--- verif/test_rfs_rx_stats.sv
// testbench: frame rows, bursts, refusals and reset for the statistics block
`timescale 1ns/1ps
module test_rfs_rx_stats import rfs_pkg::*;;
	typedef struct {logic [3:0] ctl; logic e, f, d, p; rfs_class_type c; logic [13:0] len; logic v;
		logic [13:0] bytes; logic [7:0] mask;} rfs_row_type;
	logic          pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]   paddr = 12'h000;
	logic [31:0]   pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0]    pstrb = 4'hF;
	logic          pready, pslverr, er, frame_done, frame_error, filter_fail, fifo_drop, is_pause, has_vlan;
	rfs_class_type frame_class;
	logic [13:0]   frame_len;
	logic [31:0]   exp_cnt [9];
	int            fail_count = 0, check_count = 0;
	rfs_row_type   rows [19];
	localparam rfs_class_type U = RFS_CLASS_UCAST, M = RFS_CLASS_MCAST, B = RFS_CLASS_BCAST;
	always #2.5 pclk = ~pclk;
	rfs_rx_stats i_rfs_rx_stats (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frame_done(frame_done), .frame_error(frame_error), .filter_fail(filter_fail),
		.fifo_drop(fifo_drop), .is_pause(is_pause), .frame_class(frame_class), .frame_len(frame_len),
		.has_vlan(has_vlan));
	rfs_frame_src i_rfs_frame_src (.pclk(pclk), .frame_done(frame_done), .frame_error(frame_error),
		.filter_fail(filter_fail), .fifo_drop(fifo_drop), .is_pause(is_pause), .frame_class(frame_class),
		.frame_len(frame_len), .has_vlan(has_vlan));
	// *****************************************************************
	// tasks
	// *****************************************************************
	task automatic chk(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t: read %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one transfer, held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n == 50) begin
			fail_count++;
			$display("[FAIL] %0t: no ready", $time);
			results();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd_all;
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0000_0000);
			chk(rd, exp_cnt[i]);
		end
	endtask
	// *****************************************************************
	// main sequence
	// *****************************************************************
	initial begin
		foreach (exp_cnt[i]) exp_cnt[i] = '0;
		rows = '{'{4, 0, 0, 0, 0, M, 100, 0, 100, 8'h24}, '{6, 0, 0, 0, 0, M, 100, 0, 96, 8'h24},
			'{5, 0, 0, 0, 0, M, 128, 1, 124, 8'h44}, '{7, 0, 0, 0, 0, M, 300, 1, 292, 8'h84},
			'{5, 0, 0, 0, 0, M, 100, 0, 100, 8'h24}, '{4, 0, 0, 0, 0, U, 64, 0, 0, 8'h11},
			'{4, 0, 0, 0, 0, B, 511, 0, 0, 8'h82}, '{0, 0, 0, 0, 0, B, 65, 0, 0, 8'h20},
			'{4, 0, 1, 0, 0, U, 256, 0, 0, 8'h00}, '{4, 0, 0, 1, 0, M, 255, 0, 0, 8'h00},
			'{4, 1, 0, 0, 0, M, 200, 0, 0, 8'h00}, '{4, 0, 1, 0, 1, M, 64, 0, 0, 8'h08},
			'{4, 0, 0, 0, 1, M, 64, 0, 0, 8'h08}, '{12, 0, 0, 0, 1, M, 64, 0, 64, 8'h1C},
			'{4, 0, 0, 0, 1, U, 100, 0, 0, 8'h28}, '{4, 0, 0, 0, 0, M, 127, 0, 127, 8'h24},
			'{4, 0, 0, 0, 0, U, 256, 0, 0, 8'h81}, '{4, 0, 0, 0, 0, U, 512, 0, 0, 8'h01},
			'{4, 0, 0, 0, 0, U, 63, 0, 0, 8'h01}};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, RFS_ADDR_CONTROL, 32'h0000_0000);
		chk(rd, {28'h000_0000, RFS_CTL_RESET});
		rd_all();
		// table rows: control, one frame, then every counter
		foreach (rows[r]) begin
			apb(1'b1, RFS_ADDR_CONTROL, {28'h000_0000, rows[r].ctl});
			i_rfs_frame_src.send(1, rows[r].e, rows[r].f, rows[r].d, rows[r].p, rows[r].c, rows[r].len, rows[r].v);
			exp_cnt[0] += rows[r].bytes;
			for (int j = 0; j < 8; j++) exp_cnt[j + 1] += rows[r].mask[j];
			rd_all();
		end
		// eight frames on consecutive cycles must all count
		i_rfs_frame_src.send(8, 0, 0, 0, 0, U, RFS_LEN_64, 0);
		exp_cnt[1] += 8;
		exp_cnt[5] += 8;
		rd_all();
		// counter write refused, unmapped read gives zero with error
		apb(1'b1, RFS_ADDR_UCAST_FRAMES, 32'hFFFF_FFFF);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		apb(1'b0, 12'h028, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		rd_all();
		// control write without byte strobe 0 is dropped quietly, last row's value stays
		pstrb <= 4'hE;
		apb(1'b1, RFS_ADDR_CONTROL, 32'h0000_0000);
		chk({31'h0000_0000, er}, 32'h0000_0000);
		pstrb <= 4'hF;
		apb(1'b0, RFS_ADDR_CONTROL, 32'h0000_0000);
		chk(rd, {28'h000_0000, rows[18].ctl});
		// a frame strobe while the clock enable is low must leave every count alone
		clk_en <= 1'b0;
		i_rfs_frame_src.send(1, 0, 0, 0, 0, U, RFS_LEN_64, 0);
		clk_en <= 1'b1;
		rd_all();
		// second reset in mid-run clears everything
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (exp_cnt[i]) exp_cnt[i] = '0;
		rd_all();
		apb(1'b0, RFS_ADDR_CONTROL, 32'h0000_0000);
		chk(rd, {28'h000_0000, RFS_CTL_RESET});
		results();
	end
endmodule // test_rfs_rx_stats
bind rfs_rx_stats rfs_rx_stats_chk #(.BYTE_WIDTH(BYTE_WIDTH), .FRAME_WIDTH(FRAME_WIDTH)) i_rfs_rx_stats_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_done(frame_done));
